// ===== rtl/bacd_pkg.sv
/*
  Shared constants and carrier types for the bit, arithmetic and compare
  datapath: default operand geometry, fixed selection constants and the
  packed bundle of one-bit relational and logical results.
  Assumes nothing of its surroundings; it is compiled before every module.
*/

package bacd_pkg;

  // ---------------------------------------------------------------------
  // Default operand geometry
  // ---------------------------------------------------------------------
  localparam int DEF_WIDTH     = 8;
  localparam int DEF_SIGNED    = 0;
  localparam int DEF_SHIFT     = 1;
  localparam int DEF_TAKE      = 4;
  localparam int DEF_DROP      = 4;

  // ---------------------------------------------------------------------
  // Default fixed selection constants
  // ---------------------------------------------------------------------
  localparam int DEF_BIT_IDX   = 4;
  localparam int DEF_RANGE_HI  = 7;
  localparam int DEF_RANGE_LO  = 3;
  localparam int DEF_MEM_DEPTH = 23;
  localparam int DEF_ARR_DEPTH = 4;
  localparam int DEF_ARR_IDX   = 2;

  // Lowest bit position of any operand.
  localparam int LSB_POS       = 0;

  // ---------------------------------------------------------------------
  // One-bit results of compares and logical operators
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic eq;
    logic ne;
    logic lt;
    logic gt;
    logic le;
    logic ge;
    logic nz;
    logic land;
    logic lor;
    logic lnot;
  } bacd_flags_t;

  localparam bacd_flags_t FLAGS_RST = '0;

endpackage : bacd_pkg

// ===== rtl/bacd_word_mem.sv
/*
  Small on-chip word memory: one synchronous write port and one
  asynchronous read port, so a word read can be bit-selected in the same
  cycle as the rest of the expression.
  Assumes at most one read address per cycle and a caller on the same clock.
*/

`timescale 1ns/100ps
`default_nettype none

module bacd_word_mem #(
  parameter int WIDTH = bacd_pkg::DEF_WIDTH,
  parameter int DEPTH = bacd_pkg::DEF_MEM_DEPTH,
  parameter int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  // Clock
  input  wire logic             clk,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  // ---------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------
  // Contents are not reset: a real block RAM cannot clear itself either.
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Out-of-range addresses read as zero rather than as an unknown word.
  always_comb begin
    if (int'(rd_addr) < DEPTH) begin
      rd_data = mem_q[rd_addr];
    end else begin
      rd_data = '0;
    end
  end

endmodule : bacd_word_mem

`default_nettype wire

// ===== rtl/bacd_datapath.sv
/*
  Expression datapath: constant shifts, take and drop of low bits,
  concatenation, bit and range selection on operands, memory words and
  register array elements, width query, wrapping add, subtract and
  multiply with full-width sum and product, relational compares and one-bit
  logical operators.
  Assumes operands come from logic on the same clock; all operators are
  evaluated in one combinational level and the result bank captures them
  on the next edge, as an assignment would.
*/
//
// Contract
// - Constant shifts keep the input width; bits shifted out are lost.
// - Right shift fills zeros when unsigned, copies of the top bit when signed.
// - Shift, take, drop counts and bit indices are elaboration constants.
// - Take returns only the n lowest bits of the operand.
// - Drop returns all bits except the n lowest, so it is narrower.
// - Concatenation width is the sum; left operand forms the upper bits.
// - Bit 0 is the lowest bit, bit width minus one the highest.
// - A range is upper then lower bound, inclusive, as wide as its span.
// - Bit and range selection also work on memory words and array elements.
// - Width query is a constant usable as a fixed count, e.g. for take.
// - Only add, subtract and multiply; no run-time divider is built.
// - Arithmetic operands must match in width and signedness at elaboration.
// - Arithmetic results keep operand width and wrap, losing carries.
// - Full carry or product comes from zero-extending operands first.
// - Evaluation follows C precedence: product before sum unless grouped.
// - Compares take equal widths and give one unsigned bit, 1 when true.
// - Compares are both signed or both unsigned; mixed pairs are refused.
// - A multi-bit value used as a condition is true when non-zero.
// - Logical and, or, not take and give one-bit unsigned values.
// - Wider logical inputs are first reduced by a compare with zero.
// - Operators are combinational and add no clock cycles of their own.

`timescale 1ns/100ps
`default_nettype none

module bacd_datapath #(
  parameter int WIDTH     = bacd_pkg::DEF_WIDTH,
  parameter int A_SIGNED  = bacd_pkg::DEF_SIGNED,
  parameter int B_SIGNED  = bacd_pkg::DEF_SIGNED,
  parameter int B_WIDTH   = bacd_pkg::DEF_WIDTH,
  parameter int SHIFT     = bacd_pkg::DEF_SHIFT,
  parameter int TAKE_N    = bacd_pkg::DEF_TAKE,
  parameter int DROP_N    = bacd_pkg::DEF_DROP,
  parameter int BIT_IDX   = bacd_pkg::DEF_BIT_IDX,
  parameter int RANGE_HI  = bacd_pkg::DEF_RANGE_HI,
  parameter int RANGE_LO  = bacd_pkg::DEF_RANGE_LO,
  parameter int MEM_DEPTH = bacd_pkg::DEF_MEM_DEPTH,
  parameter int ARR_DEPTH = bacd_pkg::DEF_ARR_DEPTH,
  parameter int ARR_IDX   = bacd_pkg::DEF_ARR_IDX,
  parameter int MAW       = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1,
  parameter int RW        = RANGE_HI - RANGE_LO + 1,
  parameter int DW        = WIDTH - DROP_N
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Operands
  input  wire logic [WIDTH-1:0] op_a,
  input  wire logic [WIDTH-1:0] op_b,
  input  wire logic [WIDTH-1:0] op_c,
  input  wire logic             cond_in,
  // Word memory ports
  input  wire logic             mem_wr_en,
  input  wire logic [MAW-1:0]   mem_wr_addr,
  input  wire logic [WIDTH-1:0] mem_wr_data,
  input  wire logic [MAW-1:0]   mem_rd_addr,
  // Register array load: shifts op_a into element zero
  input  wire logic             arr_load,
  // Bit manipulation results
  output logic [WIDTH-1:0]      res_shl,
  output logic [WIDTH-1:0]      res_shr,
  output logic [TAKE_N-1:0]     res_take,
  output logic [DW-1:0]         res_drop,
  output logic [2*WIDTH-1:0]    res_cat,
  output logic                  res_bit,
  output logic [RW-1:0]         res_range,
  output logic                  res_mem_bit,
  output logic [RW-1:0]         res_mem_range,
  output logic                  res_arr_bit,
  output logic [RW-1:0]         res_arr_range,
  output logic [WIDTH-1:0]      res_wtake,
  // Arithmetic results
  output logic [WIDTH-1:0]      res_sum,
  output logic [WIDTH-1:0]      res_diff,
  output logic [WIDTH-1:0]      res_prod,
  output logic [WIDTH-1:0]      res_prec,
  output logic [WIDTH:0]        res_sum_full,
  output logic [2*WIDTH-1:0]    res_prod_full,
  // Relational and logical results
  output bacd_pkg::bacd_flags_t res_flags
);

  // ---------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------
  // All counts are parameters, so nothing run-time can steer a shift,
  // a take, a drop or a bit index.
  if (B_WIDTH != WIDTH) begin : g_bad_width
    $error("bacd_datapath: operand widths differ");
  end
  if (A_SIGNED != B_SIGNED) begin : g_bad_sign
    $error("bacd_datapath: operand signedness differs");
  end
  if (SHIFT < 0 || SHIFT > WIDTH) begin : g_bad_shift
    $error("bacd_datapath: shift distance out of range");
  end
  if (TAKE_N < 1 || TAKE_N > WIDTH) begin : g_bad_take
    $error("bacd_datapath: take count out of range");
  end
  if (DROP_N < 0 || DROP_N >= WIDTH) begin : g_bad_drop
    $error("bacd_datapath: drop count out of range");
  end
  if (BIT_IDX < bacd_pkg::LSB_POS || BIT_IDX >= WIDTH) begin : g_bad_bit
    $error("bacd_datapath: bit index out of range");
  end
  if (RANGE_LO < bacd_pkg::LSB_POS || RANGE_HI >= WIDTH || RANGE_HI < RANGE_LO)
  begin : g_bad_range
    $error("bacd_datapath: bit range must be upper:lower within width");
  end
  if (ARR_DEPTH < 1 || ARR_IDX < 0 || ARR_IDX >= ARR_DEPTH) begin : g_bad_arr
    $error("bacd_datapath: array element index out of range");
  end
  // Derived widths are parameters only for the port list; they must agree.
  if (MEM_DEPTH < 1 || MAW < 1 || (2 ** MAW) < MEM_DEPTH) begin : g_bad_mem
    $error("bacd_datapath: memory depth does not fit its address");
  end
  if (RW != RANGE_HI - RANGE_LO + 1) begin : g_bad_rw
    $error("bacd_datapath: range width disagrees with its bounds");
  end
  if (DW != WIDTH - DROP_N) begin : g_bad_dw
    $error("bacd_datapath: drop width disagrees with the drop count");
  end

  // Width query: a constant, then reused as a take count.
  localparam int A_WIDTH = $bits(op_a);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [ARR_DEPTH-1:0][WIDTH-1:0] arr;
    logic [WIDTH-1:0]                shl;
    logic [WIDTH-1:0]                shr;
    logic [TAKE_N-1:0]               take;
    logic [DW-1:0]                   drop;
    logic [2*WIDTH-1:0]              cat;
    logic                            bsel;
    logic [RW-1:0]                   rsel;
    logic                            mbit;
    logic [RW-1:0]                   mrange;
    logic                            abit;
    logic [RW-1:0]                   arange;
    logic [WIDTH-1:0]                wtake;
    logic [WIDTH-1:0]                sum;
    logic [WIDTH-1:0]                diff;
    logic [WIDTH-1:0]                prod;
    logic [WIDTH-1:0]                prec;
    logic [WIDTH:0]                  sum_full;
    logic [2*WIDTH-1:0]              prod_full;
    bacd_pkg::bacd_flags_t           flags;
  } bacd_state_t;

  bacd_state_t      state_r;
  bacd_state_t      state_nxt;
  logic [WIDTH-1:0] mem_word;

  // ---------------------------------------------------------------------
  // Word memory
  // ---------------------------------------------------------------------
  bacd_word_mem #(
    .WIDTH (WIDTH),
    .DEPTH (MEM_DEPTH),
    .AW    (MAW)
  ) u_mem (
    .clk     (clk),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_addr (mem_rd_addr),
    .rd_data (mem_word)
  );

  // ---------------------------------------------------------------------
  // Operator network
  // ---------------------------------------------------------------------
  // Everything below is one combinational level; the only register is the
  // result bank, which stands in for the destination of an assignment.
  // Deep expressions lengthen this path, not the latency.
  always_comb begin
    logic [2*WIDTH-1:0] cat_v;
    logic [WIDTH-1:0]   elem_v;
    logic               a_nz;
    cat_v  = {op_a, op_b};
    elem_v = state_r.arr[ARR_IDX];
    a_nz   = (op_a != '0);

    state_nxt = state_r;

    // Register array: element zero takes op_a, the rest move up by one.
    // Indices stay constants, so a word loaded now reaches element ARR_IDX
    // only after ARR_IDX further loads.
    if (arr_load) begin
      for (int k = ARR_DEPTH - 1; k > 0; k--) begin
        state_nxt.arr[k] = state_r.arr[k - 1];
      end
      state_nxt.arr[0] = op_a;
    end

    // Shifts stay WIDTH wide; bits pushed past either end are lost.
    state_nxt.shl = op_a << SHIFT;
    if (A_SIGNED != 0) begin
      // Arithmetic shift replicates the two's complement sign bit.
      state_nxt.shr = WIDTH'($signed(op_a) >>> SHIFT);
    end else begin
      state_nxt.shr = op_a >> SHIFT;
    end

    state_nxt.take  = op_a[TAKE_N-1:0];
    state_nxt.drop  = op_a[WIDTH-1:DROP_N];
    state_nxt.cat   = cat_v;
    state_nxt.wtake = cat_v[A_WIDTH-1:0];

    // Selections on the operand, the memory word and the array element.
    state_nxt.bsel   = op_a[BIT_IDX];
    state_nxt.rsel   = op_a[RANGE_HI:RANGE_LO];
    state_nxt.mbit   = mem_word[BIT_IDX];
    state_nxt.mrange = mem_word[RANGE_HI:RANGE_LO];
    state_nxt.abit   = elem_v[BIT_IDX];
    state_nxt.arange = elem_v[RANGE_HI:RANGE_LO];

    // Add, subtract and multiply only; no divider is built.
    // Two's complement makes the wrapped bits the same for either sign.
    state_nxt.sum  = op_a + op_b;
    state_nxt.diff = op_a - op_b;
    state_nxt.prod = op_a * op_b;
    state_nxt.prec = op_a + op_b * op_c;

    // Extending by zeros first keeps the carry and the full product.
    state_nxt.sum_full  = {1'b0, op_a} + {1'b0, op_b};
    state_nxt.prod_full = {{WIDTH{1'b0}}, op_a} * {{WIDTH{1'b0}}, op_b};

    // Compares give a single unsigned bit each.
    state_nxt.flags.eq = (op_a == op_b);
    state_nxt.flags.ne = (op_a != op_b);
    if (A_SIGNED != 0) begin
      state_nxt.flags.lt = ($signed(op_a) <  $signed(op_b));
      state_nxt.flags.gt = ($signed(op_a) >  $signed(op_b));
      state_nxt.flags.le = ($signed(op_a) <= $signed(op_b));
      state_nxt.flags.ge = ($signed(op_a) >= $signed(op_b));
    end else begin
      state_nxt.flags.lt = (op_a <  op_b);
      state_nxt.flags.gt = (op_a >  op_b);
      state_nxt.flags.le = (op_a <= op_b);
      state_nxt.flags.ge = (op_a >= op_b);
    end

    // Logical operators work on one-bit values; op_a is reduced first.
    state_nxt.flags.nz   = a_nz;
    state_nxt.flags.land = a_nz & cond_in;
    state_nxt.flags.lor  = a_nz | cond_in;
    state_nxt.flags.lnot = ~a_nz;
  end

  // ---------------------------------------------------------------------
  // Result bank
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign res_shl       = state_r.shl;
  assign res_shr       = state_r.shr;
  assign res_take      = state_r.take;
  assign res_drop      = state_r.drop;
  assign res_cat       = state_r.cat;
  assign res_bit       = state_r.bsel;
  assign res_range     = state_r.rsel;
  assign res_mem_bit   = state_r.mbit;
  assign res_mem_range = state_r.mrange;
  assign res_arr_bit   = state_r.abit;
  assign res_arr_range = state_r.arange;
  assign res_wtake     = state_r.wtake;
  assign res_sum       = state_r.sum;
  assign res_diff      = state_r.diff;
  assign res_prod      = state_r.prod;
  assign res_prec      = state_r.prec;
  assign res_sum_full  = state_r.sum_full;
  assign res_prod_full = state_r.prod_full;
  assign res_flags     = state_r.flags;

endmodule : bacd_datapath

`default_nettype wire

// ===== bench/bacd_dp_props.sv
/*
  Concurrent checks for the expression datapath, bound to its top module.
  Assumes results appear one clock edge after their operands are sampled.
*/
`timescale 1ns/100ps
`default_nettype none
module bacd_dp_props #(
  parameter int WIDTH    = 8,
  parameter int A_SIGNED = 0,
  parameter int SHIFT    = 1,
  parameter int TAKE_N   = 4,
  parameter int DROP_N   = 4,
  parameter int BIT_IDX  = 4,
  parameter int RANGE_HI = 7,
  parameter int RANGE_LO = 3,
  parameter int RW       = RANGE_HI - RANGE_LO + 1,
  parameter int DW       = WIDTH - DROP_N
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  srst,
  // Operands
  input wire logic [WIDTH-1:0]      op_a,
  input wire logic [WIDTH-1:0]      op_b,
  input wire logic [WIDTH-1:0]      op_c,
  input wire logic                  cond_in,
  // Results
  input wire logic [WIDTH-1:0]      res_shl,
  input wire logic [WIDTH-1:0]      res_shr,
  input wire logic [TAKE_N-1:0]     res_take,
  input wire logic [DW-1:0]         res_drop,
  input wire logic [2*WIDTH-1:0]    res_cat,
  input wire logic                  res_bit,
  input wire logic [RW-1:0]         res_range,
  input wire logic [WIDTH-1:0]      res_sum,
  input wire logic [WIDTH-1:0]      res_prod,
  input wire logic [WIDTH-1:0]      res_prec,
  input wire logic [WIDTH:0]        res_sum_full,
  input wire bacd_pkg::bacd_flags_t res_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_shift_left_wrap: assert property (!$past(srst) |->
    res_shl == WIDTH'($past(op_a) << SHIFT)) else $error("left shift result wrong");
  a_shift_right_fill: assert property (!$past(srst) |-> res_shr == ((A_SIGNED != 0) ?
    WIDTH'($signed($past(op_a)) >>> SHIFT) : WIDTH'($past(op_a) >> SHIFT)))
    else $error("right shift fill wrong");
  a_take_drop_low: assert property (!$past(srst) |->
    res_take == $past(op_a[TAKE_N-1:0]) && res_drop == DW'($past(op_a) >> DROP_N))
    else $error("take or drop wrong");
  a_concat_order: assert property (!$past(srst) |->
    res_cat == {$past(op_a), $past(op_b)}) else $error("concatenation order wrong");
  a_bit_range_sel: assert property (!$past(srst) |-> res_bit == $past(op_a[BIT_IDX])
    && res_range == $past(op_a[RANGE_HI:RANGE_LO])) else $error("bit selection wrong");
  a_arith_wrap: assert property (!$past(srst) |->
    res_sum == WIDTH'($past(op_a) + $past(op_b))
    && res_prod == WIDTH'($past(op_a) * $past(op_b))) else $error("wrapped arithmetic wrong");
  a_full_carry: assert property (!$past(srst) |->
    res_sum_full == {1'b0, $past(op_a)} + {1'b0, $past(op_b)}) else $error("full sum wrong");
  a_prec_order: assert property (!$past(srst) |->
    res_prec == WIDTH'($past(op_a) + $past(op_b) * $past(op_c))) else $error("precedence wrong");
  a_compare_bits: assert property (!$past(srst) |->
    res_flags.eq == ($past(op_a) == $past(op_b)) && res_flags.ne == !res_flags.eq)
    else $error("equality flags wrong");
  a_order_less: assert property (!$past(srst) |-> res_flags.lt == ((A_SIGNED != 0) ?
    ($signed($past(op_a)) < $signed($past(op_b))) : ($past(op_a) < $past(op_b))))
    else $error("ordering flag wrong");
  a_logic_reduce: assert property (!$past(srst) |-> res_flags.nz == ($past(op_a) != 0)
    && res_flags.land == (res_flags.nz && $past(cond_in))) else $error("logical and wrong");
endmodule : bacd_dp_props
`default_nettype wire

// ===== bench/tb_bacd_datapath.sv
/*
  Self-checking bench for the expression datapath with default geometry.
  Assumes the checker file is compiled before this top module.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_bacd_datapath;
  // ---------------------------------------------------------------------
  // Stimulus and results
  // ---------------------------------------------------------------------
  logic                  clk, srst, cond_in, mem_wr_en, arr_load;
  logic [7:0]            op_a, op_b, op_c, mem_wr_data, res_shl, res_shr, res_wtake;
  logic [7:0]            res_sum, res_diff, res_prod, res_prec;
  logic [4:0]            mem_wr_addr, mem_rd_addr, res_range, res_mem_range, res_arr_range;
  logic [3:0]            res_take, res_drop;
  logic [15:0]           res_cat, res_prod_full;
  logic [8:0]            res_sum_full;
  logic                  res_bit, res_mem_bit, res_arr_bit;
  bacd_pkg::bacd_flags_t res_flags;
  logic [7:0]            res_shr_s;
  bacd_pkg::bacd_flags_t flags_s;
  int                    fail_count, total_checks, cycles;

  bacd_datapath dut (.clk(clk), .srst(srst), .op_a(op_a), .op_b(op_b), .op_c(op_c),
    .cond_in(cond_in), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .mem_rd_addr(mem_rd_addr), .arr_load(arr_load),
    .res_shl(res_shl), .res_shr(res_shr), .res_take(res_take), .res_drop(res_drop),
    .res_cat(res_cat), .res_bit(res_bit), .res_range(res_range), .res_mem_bit(res_mem_bit),
    .res_mem_range(res_mem_range), .res_arr_bit(res_arr_bit), .res_arr_range(res_arr_range),
    .res_wtake(res_wtake), .res_sum(res_sum), .res_diff(res_diff), .res_prod(res_prod),
    .res_prec(res_prec), .res_sum_full(res_sum_full), .res_prod_full(res_prod_full),
    .res_flags(res_flags));

  // Second copy in signed mode, watched only where signedness matters.
  bacd_datapath #(.A_SIGNED(1), .B_SIGNED(1)) dut_s (.clk(clk), .srst(srst), .op_a(op_a),
    .op_b(op_b), .op_c(op_c), .cond_in(cond_in), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_rd_addr(mem_rd_addr),
    .arr_load(arr_load), .res_shl(), .res_shr(res_shr_s), .res_take(), .res_drop(),
    .res_cat(), .res_bit(), .res_range(), .res_mem_bit(), .res_mem_range(), .res_arr_bit(),
    .res_arr_range(), .res_wtake(), .res_sum(), .res_diff(), .res_prod(), .res_prec(),
    .res_sum_full(), .res_prod_full(), .res_flags(flags_s));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Overall cycle budget; a hang is counted as a failure.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      close_out();
    end
  end

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic apply(input logic [7:0] a, b, c, input logic cnd);
    @(posedge clk);
    op_a <= a; op_b <= b; op_c <= c; cond_in <= cnd;
    @(posedge clk);
    #1;
  endtask : apply

  task automatic mem_wr(input logic [4:0] addr, input logic [7:0] data);
    @(posedge clk);
    mem_wr_en <= 1'b1; mem_wr_addr <= addr; mem_wr_data <= data;
    @(posedge clk);
    mem_wr_en <= 1'b0;
  endtask : mem_wr

  task automatic mem_rd(input logic [4:0] addr);
    @(posedge clk);
    mem_rd_addr <= addr;
    @(posedge clk);
    #1;
  endtask : mem_rd

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_bits;
    apply(8'hC7, 8'h0C, 8'h00, 1'b0);
    `CHK(res_take, 4'h7)
    `CHK(res_drop, 4'hC)
    `CHK(res_cat, 16'hC70C)
    `CHK(res_wtake, 8'h0C)
    `CHK(res_shl, 8'h8E)
    apply(8'hC0, 8'h00, 8'h00, 1'b0);
    `CHK(res_shr, 8'h60)
    `CHK(res_shr_s, 8'hE0)
    apply(8'hF8, 8'h00, 8'h00, 1'b0);
    `CHK(res_shr, 8'h7C)
    `CHK(res_shr_s, 8'hFC)
    apply(8'h49, 8'h00, 8'h00, 1'b0);
    `CHK(res_bit, 1'b0)
    `CHK(res_range, 5'h09)
    $display("test bits done");
  endtask : t_bits

  task automatic t_arith;
    apply(8'h80, 8'hC0, 8'h00, 1'b0);
    `CHK(res_sum, 8'h40)
    `CHK(res_sum_full, 9'h140)
    apply(8'h02, 8'hC0, 8'h03, 1'b0);
    `CHK(res_prod, 8'h80)
    `CHK(res_prod_full, 16'h0180)
    `CHK(res_diff, 8'h42)
    `CHK(res_prec, 8'h42)
    apply(8'h02, 8'h03, 8'h04, 1'b0);
    `CHK(res_diff, 8'hFF)
    `CHK(res_prec, 8'h0E)
    $display("test arith done");
  endtask : t_arith

  task automatic t_compare;
    logic [7:0]            av [6] = '{8'h05, 8'h09, 8'h07, 8'h80, 8'h00, 8'h00};
    logic [7:0]            bv [6] = '{8'h09, 8'h05, 8'h07, 8'h7F, 8'h00, 8'h01};
    bacd_pkg::bacd_flags_t e;
    for (int i = 0; i < 6; i++) begin
      apply(av[i], bv[i], 8'h00, i[0]);
      e = '{eq: av[i] == bv[i], ne: av[i] != bv[i], lt: av[i] < bv[i], gt: av[i] > bv[i],
            le: av[i] <= bv[i], ge: av[i] >= bv[i], nz: av[i] != 0,
            land: (av[i] != 0) && i[0], lor: (av[i] != 0) || i[0], lnot: av[i] == 0};
      `CHK(res_flags, e)
      `CHK(flags_s.lt, $signed(av[i]) < $signed(bv[i]))
    end
    $display("test compare done");
  endtask : t_compare

  task automatic t_mem;
    mem_wr(5'd10, 8'h4C);
    mem_wr(5'd22, 8'hFF);
    mem_rd(5'd10);
    `CHK(res_mem_range, 5'h09)
    `CHK(res_mem_bit, 1'b0)
    mem_rd(5'd22);
    `CHK(res_mem_range, 5'h1F)
    // A write and a read of one word in the same cycle still shows the old word.
    @(posedge clk);
    mem_wr_en <= 1'b1; mem_wr_addr <= 5'd10; mem_wr_data <= 8'hB3; mem_rd_addr <= 5'd10;
    @(posedge clk);
    mem_wr_en <= 1'b0;
    #1;
    `CHK(res_mem_range, 5'h09)
    mem_rd(5'd10);
    `CHK(res_mem_range, 5'h16)
    `CHK(res_mem_bit, 1'b1)
    $display("test mem done");
  endtask : t_mem

  task automatic t_array;
    @(posedge clk);
    arr_load <= 1'b1; op_a <= 8'h11;
    @(posedge clk);
    op_a <= 8'h22;
    @(posedge clk);
    op_a <= 8'h33;
    @(posedge clk);
    arr_load <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(res_arr_range, 5'h02)
    `CHK(res_arr_bit, 1'b1)
    // Reset in mid-run clears the results and the register array.
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK(res_cat, 16'h0000)
    `CHK(res_arr_range, 5'h00)
    // One edge later the result shows the cleared array element itself.
    @(posedge clk);
    #1;
    `CHK(res_arr_range, 5'h00)
    $display("test array done");
  endtask : t_array

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  initial begin
    srst = 1'b1; op_a = '0; op_b = '0; op_c = '0; cond_in = 1'b0; arr_load = 1'b0;
    mem_wr_en = 1'b0; mem_wr_addr = '0; mem_wr_data = '0; mem_rd_addr = '0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_bits();
    t_arith();
    t_compare();
    t_mem();
    t_array();
    close_out();
  end
endmodule : tb_bacd_datapath

bind bacd_datapath bacd_dp_props #(.WIDTH(WIDTH), .A_SIGNED(A_SIGNED), .SHIFT(SHIFT),
  .TAKE_N(TAKE_N), .DROP_N(DROP_N), .BIT_IDX(BIT_IDX), .RANGE_HI(RANGE_HI),
  .RANGE_LO(RANGE_LO)) u_props (.clk(clk), .srst(srst), .op_a(op_a), .op_b(op_b),
  .op_c(op_c), .cond_in(cond_in), .res_shl(res_shl), .res_shr(res_shr),
  .res_take(res_take), .res_drop(res_drop), .res_cat(res_cat), .res_bit(res_bit),
  .res_range(res_range), .res_sum(res_sum), .res_prod(res_prod), .res_prec(res_prec),
  .res_sum_full(res_sum_full), .res_flags(res_flags));
`default_nettype wire
